// [can_irq_pkg.sv]
package can_irq_pkg;
   // register byte addresses on the register bus
   localparam logic [15:0] FLAGS_ADDR = 16'h1050;
   localparam logic [15:0] MASK_ADDR = 16'h1054;
   localparam logic [15:0] CTRL_ADDR = 16'h1058;
   localparam logic [15:0] STAT_ADDR = 16'h105c;
   localparam int ADDR_W = 16;
   // flag positions inside the interrupt flag register
   localparam int DEDICATED_STORED_POS = 19;
   localparam int TIMEOUT_POS = 18;
   localparam int RAM_FAIL_POS = 17;
   localparam int TS_WRAP_POS = 16;
   localparam int TEF_LOST_POS = 15;
   localparam int TEF_FULL_POS = 14;
   localparam int FLAG_LSB = 14;
   localparam int FLAG_COUNT = 6;
   // reset values
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [5:0] TEF_SIZE_RESET = 6'h00;
   // control register fields
   localparam int CTRL_RESTRICT_POS = 0;
   localparam int CTRL_TEF_SIZE_LSB = 8;
   localparam int TEF_SIZE_W = 6;
   // status register fields
   localparam int STAT_RESTRICT_POS = 0;
   localparam int STAT_TEF_FULL_POS = 1;
   localparam int STAT_PUT_LSB = 8;
   localparam int PUT_INDEX_W = 6;
   localparam logic [5:0] PUT_INDEX_RESET = 6'h00;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : can_irq_pkg

// [flag_bank.sv]
`timescale 1ns/1ps
// sticky flags: hardware sets, software clears by writing one
module flag_bank #(
   parameter int WIDTH = 6
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // per-bit set and clear strobes
   input wire logic [WIDTH-1:0] set_vec,
   input wire logic [WIDTH-1:0] clr_vec,
   // flag state
   output logic [WIDTH-1:0] flags
);
   import can_irq_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] flags; // held flags
   } bank_type;

   bank_type state;
   bank_type next_state;

   // per-bit next value, set beats clear in the same cycle
   always_comb begin
      next_state = state;
      for (int i = 0; i < WIDTH; i++) begin
         next_state.flags[i] = set_vec[i] | (state.flags[i] & ~clr_vec[i]);
      end
   end

   // register with synchronous reset to all clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state.flags <= FLAGS_RESET[FLAG_LSB +: WIDTH];
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign flags = state.flags;
endmodule : flag_bank

// [rx_store_guard.sv]
`timescale 1ns/1ps
// watches receive storage, aborts late or failed work
module rx_store_guard #(
   parameter int IDX_W = 6
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // from the receive handler
   input wire logic arb_field_done,
   input wire logic handler_busy,
   input wire logic write_fail,
   input wire logic store_done,
   input wire logic to_dedicated,
   // to the receive handler and flags
   output logic abort,
   output logic ram_fail_event,
   output logic dedicated_event,
   output logic new_data,
   output logic [IDX_W-1:0] put_index
);
   import can_irq_pkg::*;

   typedef struct packed {
      logic failed;              // current message already failed
      logic abort;               // abort pulse to handler
      logic dedicated_event;     // good store into dedicated buffer
      logic new_data;            // new-data strobe for that buffer
      logic [IDX_W-1:0] put_idx; // fifo put index
   } guard_type;

   guard_type state;
   guard_type next_state;
   logic late;
   logic fail_now;

   // next message header arrived while still filtering or storing
   assign late = arb_field_done & handler_busy;
   assign fail_now = late | write_fail;

   // abort pulse, commit of intact messages, index step
   always_comb begin
      next_state = state;
      next_state.abort = fail_now; // [RULE_03] [RULE_04]
      next_state.dedicated_event = 1'b0;
      next_state.new_data = 1'b0;
      // a fresh header starts a clean message
      if (arb_field_done) begin
         next_state.failed = 1'b0; // [RULE_03]
      end
      if (write_fail) begin
         next_state.failed = 1'b1; // [RULE_04]
      end
      // commit only an intact message; a failed one is overwritten
      if (store_done && !state.failed && !write_fail) begin
         if (to_dedicated) begin
            next_state.new_data = 1'b1; // [RULE_05]
            next_state.dedicated_event = 1'b1; // [RULE_01]
         end else begin
            next_state.put_idx = state.put_idx + 1'b1; // [RULE_05]
         end
      end
   end

   // register with synchronous reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state.failed <= 1'b0;
         state.abort <= 1'b0;
         state.dedicated_event <= 1'b0;
         state.new_data <= 1'b0;
         state.put_idx <= PUT_INDEX_RESET[IDX_W-1:0];
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign abort = state.abort;
   assign ram_fail_event = state.abort;
   assign dedicated_event = state.dedicated_event;
   assign new_data = state.new_data;
   assign put_index = state.put_idx;
endmodule : rx_store_guard

// [can_irq_flags.sv]
// Overview of operation
// [RULE_01] dedicated buffer store sets bit 19
// [RULE_02] timeout reached sets bit 18
// [RULE_03] late receive work aborted, sets bit 17
// [RULE_04] failed receive RAM write sets bit 17
// [RULE_05] failed message: no index or new-data update
// [RULE_06] late transmit RAM read aborts, sets 17
// [RULE_07] transmit failure holds restricted mode until cleared
// [RULE_08] timestamp counter wrap sets bit 16
// [RULE_09] element lost or size-zero write sets 15
// [RULE_10] transmit event fifo becoming full sets 14
// [RULE_11] flag register at 0x1050, resets zero
// [RULE_12] flags sticky, host writes one to clear
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module can_irq_flags (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // axi4-lite write address
   input wire logic [can_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [can_irq_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // receive handler side
   input wire logic rx_arb_field_done,
   input wire logic rx_handler_busy,
   input wire logic rx_write_fail,
   input wire logic rx_store_done,
   input wire logic rx_to_dedicated,
   output logic rx_abort,
   output logic rx_new_data,
   output logic [can_irq_pkg::PUT_INDEX_W-1:0] rx_put_index,
   // transmit handler side
   input wire logic tx_read_late,
   output logic tx_abort,
   output logic restricted_mode,
   // transmit event fifo
   input wire logic tef_element_lost,
   input wire logic tef_write_attempt,
   input wire logic [can_irq_pkg::TEF_SIZE_W-1:0] tef_fill_level,
   output logic [can_irq_pkg::TEF_SIZE_W-1:0] tef_size,
   // timers
   input wire logic timeout_reached,
   input wire logic timestamp_wrap,
   // interrupt
   output logic irq
);
   import can_irq_pkg::*;

   typedef struct packed {
      logic aw_held;                 // write address latched
      logic [ADDR_W-1:0] aw_addr;    // latched write address
      logic w_held;                  // write data latched
      logic [31:0] w_data;           // latched write data
      logic [3:0] w_strb;            // latched byte enables
      logic bvalid;                  // write response pending
      logic [1:0] bresp;             // write response code
      logic rvalid;                  // read data pending
      logic [31:0] rdata;            // read data
      logic [1:0] rresp;             // read response code
      logic [FLAG_COUNT-1:0] mask;   // interrupt enables
      logic restrict_on;             // restricted operation
      logic [TEF_SIZE_W-1:0] tef_sz; // configured fifo size
      logic tef_full_prev;           // full level last cycle
      logic tx_abort;                // abort pulse to tx handler
      logic irq;                     // registered interrupt
      logic awready;                 // write address ready
      logic wready;                  // write data ready
      logic arready;                 // read address ready
   } top_type;

   top_type state;
   top_type next_state;

   // flag bank wiring
   logic [FLAG_COUNT-1:0] flags;
   logic [FLAG_COUNT-1:0] set_vec;
   logic [FLAG_COUNT-1:0] clr_vec;
   // receive guard wiring
   logic rx_fail_event;
   logic rx_ded_event;
   logic rx_abort_w;
   logic rx_new_w;
   logic [PUT_INDEX_W-1:0] rx_put_w;
   // decoded helpers
   logic do_write;
   logic tef_full;
   logic tef_lost_event;
   logic [31:0] wmask;
   logic [31:0] flags_word;
   logic [31:0] mask_word;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;

   // receive storage guard
   rx_store_guard #(.IDX_W(PUT_INDEX_W)) u_rx_guard (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .arb_field_done(rx_arb_field_done),
      .handler_busy(rx_handler_busy),
      .write_fail(rx_write_fail),
      .store_done(rx_store_done),
      .to_dedicated(rx_to_dedicated),
      .abort(rx_abort_w),
      .ram_fail_event(rx_fail_event),
      .dedicated_event(rx_ded_event),
      .new_data(rx_new_w),
      .put_index(rx_put_w)
   );

   // sticky flags
   flag_bank #(.WIDTH(FLAG_COUNT)) u_flags (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .set_vec(set_vec),
      .clr_vec(clr_vec),
      .flags(flags)
   );

   // fifo full level: only a nonzero size can be full
   assign tef_full = (state.tef_sz != '0) && (tef_fill_level >= state.tef_sz);
   // lost element, or a write into a zero-sized fifo
   assign tef_lost_event = tef_element_lost |
      (tef_write_attempt & (state.tef_sz == '0)); // [RULE_09]

   // event to flag mapping
   always_comb begin
      set_vec = '0;
      set_vec[DEDICATED_STORED_POS-FLAG_LSB] = rx_ded_event; // [RULE_01]
      set_vec[TIMEOUT_POS-FLAG_LSB] = timeout_reached; // [RULE_02]
      set_vec[RAM_FAIL_POS-FLAG_LSB] = rx_fail_event | tx_read_late; // [RULE_06]
      set_vec[TS_WRAP_POS-FLAG_LSB] = timestamp_wrap; // [RULE_08]
      set_vec[TEF_LOST_POS-FLAG_LSB] = tef_lost_event; // [RULE_09]
      set_vec[TEF_FULL_POS-FLAG_LSB] = tef_full & ~state.tef_full_prev; // [RULE_10]
   end

   // byte enables expanded to bits
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[8*b +: 8] = {8{state.w_strb[b]}};
      end
   end

   // a write executes once address and data are both held
   assign do_write = state.aw_held & state.w_held & ~state.bvalid;

   // write one to clear, zero leaves the flag alone
   always_comb begin
      clr_vec = '0;
      if (do_write && state.aw_addr == FLAGS_ADDR) begin
         clr_vec = state.w_data[FLAG_LSB +: FLAG_COUNT] &
            wmask[FLAG_LSB +: FLAG_COUNT]; // [RULE_12]
      end
   end

   // read views of each register, unused bits zero
   always_comb begin
      flags_word = FLAGS_RESET;
      flags_word[FLAG_LSB +: FLAG_COUNT] = flags; // [RULE_11]
      mask_word = MASK_RESET;
      mask_word[FLAG_LSB +: FLAG_COUNT] = state.mask;
      ctrl_word = '0;
      ctrl_word[CTRL_RESTRICT_POS] = state.restrict_on;
      ctrl_word[CTRL_TEF_SIZE_LSB +: TEF_SIZE_W] = state.tef_sz;
      stat_word = '0;
      stat_word[STAT_RESTRICT_POS] = state.restrict_on;
      stat_word[STAT_TEF_FULL_POS] = tef_full;
      stat_word[STAT_PUT_LSB +: PUT_INDEX_W] = rx_put_w;
   end

   // bus slave, control and interrupt next state
   always_comb begin
      next_state = state;
      next_state.tef_full_prev = tef_full;
      next_state.tx_abort = tx_read_late; // [RULE_06]
      // accept write address and data in either order
      if (s_axi_awvalid && !state.aw_held && !state.bvalid) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state.w_held && !state.bvalid) begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata;
         next_state.w_strb = s_axi_wstrb;
      end
      // perform the write and raise the response
      if (do_write) begin
         next_state.aw_held = 1'b0;
         next_state.w_held = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = RESP_OKAY;
         case (state.aw_addr)
            FLAGS_ADDR: begin
               // clears are applied in the flag bank
            end
            MASK_ADDR: begin
               next_state.mask = (state.w_data[FLAG_LSB +: FLAG_COUNT] &
                  wmask[FLAG_LSB +: FLAG_COUNT]) |
                  (state.mask & ~wmask[FLAG_LSB +: FLAG_COUNT]);
            end
            CTRL_ADDR: begin
               if (state.w_strb[0]) begin
                  next_state.restrict_on = state.w_data[CTRL_RESTRICT_POS];
               end
               if (state.w_strb[1]) begin
                  next_state.tef_sz =
                     state.w_data[CTRL_TEF_SIZE_LSB +: TEF_SIZE_W];
               end
            end
            STAT_ADDR: begin
               // read only, write ignored
            end
            default: begin
               next_state.bresp = RESP_SLVERR;
            end
         endcase
      end
      // response leaves when taken
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end
      // transmit failure wins over a host clear in the same cycle
      if (tx_read_late) begin
         next_state.restrict_on = 1'b1; // [RULE_07]
      end
      // read: one outstanding, answered the cycle after the address
      if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !state.rvalid) begin
         next_state.rvalid = 1'b1;
         next_state.rresp = RESP_OKAY;
         case (s_axi_araddr)
            FLAGS_ADDR: next_state.rdata = flags_word;
            MASK_ADDR: next_state.rdata = mask_word;
            CTRL_ADDR: next_state.rdata = ctrl_word;
            STAT_ADDR: next_state.rdata = stat_word;
            default: begin
               next_state.rdata = '0;
               next_state.rresp = RESP_SLVERR;
            end
         endcase
      end
      // level interrupt from flags as they stand after this cycle
      next_state.irq = |(((flags & ~clr_vec) | set_vec) & next_state.mask);
      // readies follow the held state of the coming cycle
      next_state.awready = ~next_state.aw_held & ~next_state.bvalid;
      next_state.wready = ~next_state.w_held & ~next_state.bvalid;
      next_state.arready = ~next_state.rvalid;
   end

   // register with synchronous reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state.aw_held <= 1'b0;
         state.aw_addr <= '0;
         state.w_held <= 1'b0;
         state.w_data <= '0;
         state.w_strb <= '0;
         state.bvalid <= 1'b0;
         state.bresp <= RESP_OKAY;
         state.rvalid <= 1'b0;
         state.rdata <= '0;
         state.rresp <= RESP_OKAY;
         state.mask <= MASK_RESET[FLAG_LSB +: FLAG_COUNT];
         state.restrict_on <= 1'b0;
         state.tef_sz <= TEF_SIZE_RESET;
         state.tef_full_prev <= 1'b0;
         state.tx_abort <= 1'b0;
         state.irq <= 1'b0;
         state.awready <= 1'b1;
         state.wready <= 1'b1;
         state.arready <= 1'b1;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = state.awready;
   assign s_axi_wready = state.wready;
   assign s_axi_bvalid = state.bvalid;
   assign s_axi_bresp = state.bresp;
   assign s_axi_arready = state.arready;
   assign s_axi_rvalid = state.rvalid;
   assign s_axi_rdata = state.rdata;
   assign s_axi_rresp = state.rresp;
   assign rx_abort = rx_abort_w;
   assign rx_new_data = rx_new_w;
   assign rx_put_index = rx_put_w;
   assign tx_abort = state.tx_abort;
   assign restricted_mode = state.restrict_on;
   assign tef_size = state.tef_sz;
   assign irq = state.irq;
endmodule : can_irq_flags

// [can_irq_flags_chk.sv]
`timescale 1ns/1ps
// watches the flag block's handler-side ports
module can_irq_flags_chk (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // receive handler side
   input wire logic rx_arb_field_done,
   input wire logic rx_handler_busy,
   input wire logic rx_write_fail,
   input wire logic rx_store_done,
   input wire logic rx_to_dedicated,
   input wire logic rx_abort,
   input wire logic rx_new_data,
   input wire logic [can_irq_pkg::PUT_INDEX_W-1:0] rx_put_index,
   // transmit handler side
   input wire logic tx_read_late,
   input wire logic tx_abort,
   input wire logic restricted_mode
);
   import can_irq_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // next header while still busy
   sequence s_late_hdr;
      ce && rx_arb_field_done && rx_handler_busy;
   endsequence
   // failed write followed at once by a store
   sequence s_fail_then_store;
      (ce && rx_write_fail) ##1 (rx_store_done && !rx_arb_field_done);
   endsequence
   property p_late_abort;
      s_late_hdr |=> rx_abort;
   endproperty
   a_late_abort: assert property (p_late_abort)
      else $error("late header not aborted");
   property p_fail_abort;
      ce && rx_write_fail |=> rx_abort;
   endproperty
   a_fail_abort: assert property (p_fail_abort)
      else $error("failed write not aborted");
   property p_abort_cause;
      rx_abort |-> $past(rx_write_fail || (rx_arb_field_done && rx_handler_busy));
   endproperty
   a_abort_cause: assert property (p_abort_cause)
      else $error("receive abort without cause");
   property p_fail_quiet;
      s_fail_then_store |=> !rx_new_data && $stable(rx_put_index);
   endproperty
   a_fail_quiet: assert property (p_fail_quiet)
      else $error("failed store updated index or new data");
   property p_new_data_cause;
      rx_new_data |-> $past(rx_store_done && rx_to_dedicated);
   endproperty
   a_new_data_cause: assert property (p_new_data_cause)
      else $error("new data without dedicated store");
   property p_put_step;
      $changed(rx_put_index) |-> rx_put_index == $past(rx_put_index) + 6'h01;
   endproperty
   a_put_step: assert property (p_put_step)
      else $error("put index moved by other than one");
   property p_tx_abort;
      ce && tx_read_late |=> tx_abort && restricted_mode;
   endproperty
   a_tx_abort: assert property (p_tx_abort)
      else $error("late transmit read not aborted");
   property p_tx_cause;
      tx_abort |-> $past(tx_read_late);
   endproperty
   a_tx_cause: assert property (p_tx_cause)
      else $error("transmit abort without cause");
   property p_restrict_rise;
      $rose(restricted_mode) |-> $past(tx_read_late);
   endproperty
   a_restrict_rise: assert property (p_restrict_rise)
      else $error("restricted mode entered without cause");
endmodule : can_irq_flags_chk

bind can_irq_flags can_irq_flags_chk chk_i (.*);

// [axi_host.sv]
`timescale 1ns/1ps
// host processor model: one axi4-lite access at a time
module axi_host (
   // clock
   input wire logic mclk,
   // write side
   output logic [can_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read side
   output logic [can_irq_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   import can_irq_pkg::*;
   // idle bus at time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'h0;
   end
   // write word, channels released as taken, bounded wait
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [1:0] r, output bit ok);
      ok = 0;
      r = 2'h3;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            ok = 1;
         end
      end
   endtask : wr
   // read word, bounded wait
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
      output logic [1:0] r, output bit ok);
      ok = 0;
      r = 2'h3;
      d = '0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            ok = 1;
         end
      end
   endtask : rd
endmodule : axi_host

// [tb_can_irq_flags.sv]
`timescale 1ns/1ps
module tb_can_irq_flags;
   import can_irq_pkg::*;
   logic mclk, rst_n, ce;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [7:0] ev; // event pulses
   logic rx_handler_busy, rx_to_dedicated, rx_abort, rx_new_data;
   logic tx_abort, restricted_mode, irq;
   logic [PUT_INDEX_W-1:0] rx_put_index;
   logic [TEF_SIZE_W-1:0] tef_fill_level, tef_size;
   int miscompares, n_tests;
   logic [31:0] rv;
   logic [1:0] rr;
   bit ok;
   // single-event table: pulse and expected flag
   logic [7:0] evt [6] = '{8'h04, 8'h40, 8'h80, 8'h10, 8'h20, 8'h08};
   int pos [6] = '{DEDICATED_STORED_POS, TIMEOUT_POS, TS_WRAP_POS,
      TEF_LOST_POS, TEF_LOST_POS, RAM_FAIL_POS};
   can_irq_flags uut (.*, .rx_arb_field_done(ev[0]),
      .rx_write_fail(ev[1]), .rx_store_done(ev[2]), .tx_read_late(ev[3]),
      .tef_element_lost(ev[4]), .tef_write_attempt(ev[5]),
      .timeout_reached(ev[6]), .timestamp_wrap(ev[7]));
   axi_host host (.*);
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // bus write with response check
   task automatic w(input logic [15:0] a, input logic [31:0] d,
      input logic [1:0] er);
      host.wr(a, d, rr, ok);
      if (!ok) begin
         miscompares++;
         wrap_up();
      end
      chk(32'(rr), 32'(er));
   endtask : w
   // bus read with data and response check
   task automatic rc(input logic [15:0] a, input logic [31:0] e,
      input logic [1:0] er);
      host.rd(a, rv, rr, ok);
      if (!ok) begin
         miscompares++;
         wrap_up();
      end
      chk(rv, e);
      chk(32'(rr), 32'(er));
   endtask : rc
   // two back-to-back event cycles, then idle
   task automatic pulse(input logic [7:0] m1, input logic [7:0] m2);
      @(posedge mclk);
      ev <= m1;
      @(posedge mclk);
      ev <= m2;
      @(posedge mclk);
      ev <= 8'h00;
      @(posedge mclk);
   endtask : pulse
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      ev = 8'h00;
      {rx_handler_busy, rx_to_dedicated} = 2'h0;
      tef_fill_level = '0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      rc(FLAGS_ADDR, FLAGS_RESET, RESP_OKAY);
      w(FLAGS_ADDR, 32'hffff_ffff, RESP_OKAY);
      rc(FLAGS_ADDR, 32'h0, RESP_OKAY);
      rc(16'h1100, 32'h0, RESP_SLVERR);
      w(16'h1100, 32'h1, RESP_SLVERR);
      $display("test reset done");
      // each event sets its flag, holds through zero write, clears on one
      rx_to_dedicated <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         pulse(evt[k], 8'h00);
         rc(FLAGS_ADDR, 32'h1 << pos[k], RESP_OKAY);
         w(FLAGS_ADDR, 32'h0, RESP_OKAY);
         rc(FLAGS_ADDR, 32'h1 << pos[k], RESP_OKAY);
         w(FLAGS_ADDR, 32'h1 << pos[k], RESP_OKAY);
         rc(FLAGS_ADDR, 32'h0, RESP_OKAY);
      end
      chk(32'(restricted_mode), 32'h1);
      rc(STAT_ADDR, 32'h1, RESP_OKAY);
      w(CTRL_ADDR, 32'h0, RESP_OKAY);
      chk(32'(restricted_mode), 32'h0);
      $display("test events done");
      // late header, then failed dedicated and fifo stores
      rx_handler_busy <= 1'b1;
      pulse(8'h01, 8'h00);
      rx_handler_busy <= 1'b0;
      rc(FLAGS_ADDR, 32'h1 << RAM_FAIL_POS, RESP_OKAY);
      w(FLAGS_ADDR, 32'h1 << RAM_FAIL_POS, RESP_OKAY);
      pulse(8'h02, 8'h04);
      rc(FLAGS_ADDR, 32'h1 << RAM_FAIL_POS, RESP_OKAY);
      rx_to_dedicated <= 1'b0;
      pulse(8'h01, 8'h00);
      pulse(8'h02, 8'h04);
      chk(32'(rx_put_index), 32'h0);
      pulse(8'h01, 8'h04);
      chk(32'(rx_put_index), 32'h1);
      rc(STAT_ADDR, 32'h0000_0100, RESP_OKAY);
      w(FLAGS_ADDR, 32'h1 << RAM_FAIL_POS, RESP_OKAY);
      rc(FLAGS_ADDR, 32'h0, RESP_OKAY);
      $display("test receive done");
      // masked and unmasked interrupt
      w(MASK_ADDR, 32'h1 << TIMEOUT_POS, RESP_OKAY);
      rc(MASK_ADDR, 32'h1 << TIMEOUT_POS, RESP_OKAY);
      pulse(8'h80, 8'h40);
      repeat (2) @(posedge mclk);
      chk(32'(irq), 32'h1);
      w(FLAGS_ADDR, 32'h1 << TIMEOUT_POS, RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk(32'(irq), 32'h0);
      rc(FLAGS_ADDR, 32'h1 << TS_WRAP_POS, RESP_OKAY);
      w(FLAGS_ADDR, 32'h1 << TS_WRAP_POS, RESP_OKAY);
      $display("test interrupt done");
      // transmit event fifo of size two
      w(CTRL_ADDR, 32'h0000_0200, RESP_OKAY);
      chk(32'(tef_size), 32'h2);
      rc(CTRL_ADDR, 32'h0000_0200, RESP_OKAY);
      tef_fill_level <= 6'h01;
      pulse(8'h20, 8'h00);
      rc(FLAGS_ADDR, 32'h0, RESP_OKAY);
      tef_fill_level <= 6'h02;
      rc(FLAGS_ADDR, 32'h1 << TEF_FULL_POS, RESP_OKAY);
      w(FLAGS_ADDR, 32'h1 << TEF_FULL_POS, RESP_OKAY);
      rc(FLAGS_ADDR, 32'h0, RESP_OKAY);
      $display("test tx event fifo done");
      wrap_up();
   end
endmodule : tb_can_irq_flags
